// ===== asq_ctrl.sv
// Top of the converter sequencing block: AXI4-Lite registers, channel sequencing, results.
// Assumes one 100 MHz clock, synchronous active-high reset and a synchronous comparator.
//
// Behaviour
// - The start-channel field picks any channel as the first of a sequence, unmasked, and the sequence steps upward from it.
// - With the special-channel bit set, internal references are converted, the start-channel field picking which one.
// - Control two holds a justification bit whose reset value gives the old right alignment.
// - Control three holds result-FIFO and single-conversion bits; single overrides the four/eight length; resets keep old behaviour.
// - A write to control four aborts any sequence and starts a new one at once.
// - Writes to control two or three do not restart a running sequence, though a control three write can change its length.
// - A write to control five aborts any sequence, clears the sequence-complete flag and starts a new one.
// - In scan mode the sequence-complete flag is set at the end of every sequence.
// - Reading the test register returns the approximation register.
// - Writing the converter-reset bit of the test register resets the converter logic.
`timescale 1ns/100ps
`default_nettype none
module asq_ctrl #(
	parameter int BITS = asq_pkg::SAR_BITS
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst,
	// AXI4-Lite write address
	input  wire logic            s_axi_awvalid,
	output logic                 s_axi_awready,
	input  wire logic [7:0]      s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic            s_axi_wvalid,
	output logic                 s_axi_wready,
	input  wire logic [31:0]     s_axi_wdata,
	input  wire logic [3:0]      s_axi_wstrb,
	// AXI4-Lite write response
	output logic                 s_axi_bvalid,
	input  wire logic            s_axi_bready,
	output logic      [1:0]      s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic            s_axi_arvalid,
	output logic                 s_axi_arready,
	input  wire logic [7:0]      s_axi_araddr,
	// AXI4-Lite read data
	output logic                 s_axi_rvalid,
	input  wire logic            s_axi_rready,
	output logic      [31:0]     s_axi_rdata,
	output logic      [1:0]      s_axi_rresp,
	// Analog multiplexer and comparator
	output logic      [2:0]      mux_chan,
	output logic                 mux_special,
	output logic      [BITS-1:0] dac_trial,
	input  wire logic            cmp_high,
	// Interrupt
	output logic                 irq
);
	// Whole block state: bus holding registers, control fields, sequencer and divider
	typedef struct packed {
		logic        aw_got;
		logic [7:0]  aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic        rpend;
		logic [7:0]  ar_addr;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [1:0]  ctl2;
		logic [1:0]  ctl3;
		logic [3:0]  ctl4;
		logic [5:0]  ctl5;
		logic [1:0]  status;
		logic [1:0]  mask;
		logic [2:0]  step;
		logic [2:0]  slot;
		logic        active;
		logic        kick;
		logic [4:0]  divcnt;
	} asq_ctrl_t;
	asq_ctrl_t s_reg, s_next;

	logic [BITS-1:0] sar_trial;
	logic            sar_busy;
	logic            sar_done;
	logic [15:0]     ram_rd;
	logic [15:0]     ram_wd;
	logic            tick;
	logic            wr_fire;
	logic            conv_abort;
	logic [2:0]      seq_len_m1;
	logic [2:0]      rd_slot;

	// Sequence length: single wins, else eight or four
	// A control three write changes the length of the running sequence without a restart
	always_comb begin
		if (s_reg.ctl3[asq_pkg::CTL3_SINGLE]) begin
			seq_len_m1 = 3'h0;
		end else if (s_reg.ctl5[asq_pkg::CTL5_EIGHT]) begin
			seq_len_m1 = 3'h7;
		end else begin
			seq_len_m1 = 3'h3;
		end
	end

	// Conversion rate divider from control four: one tick every ctl4 + 2 clocks.
	// The count is one bit wider than the field so the slowest rate cannot wrap
	// into a tick on every clock.
	assign tick = (s_reg.divcnt == 5'h00);

	// Write fires when both address and data are held and the response slot is free
	// Holding back on a pending response keeps a second write from overrunning it
	assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;

	// Result justification: right aligned by default, left when selected
	assign ram_wd = s_reg.ctl2[asq_pkg::CTL2_JUSTIFY] ?
		{sar_trial, {(16-BITS){1'b0}}} : {{(16-BITS){1'b0}}, sar_trial};

	// Read slot: the store is addressed from the bus as the read address is taken,
	// so its registered data are ready on the edge that loads the read data.
	// Using the held address instead would hand back the previous slot.
	assign rd_slot = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr[4:2] : s_reg.ar_addr[4:2];

	// Aborts come from writes to control four, five or the test reset bit
	// A test reset aborts without a restart: its clear of active below wins
	always_comb begin
		conv_abort = 1'b0;
		if (wr_fire) begin
			case (s_reg.aw_addr)
				asq_pkg::OFF_CTL4: conv_abort = 1'b1;
				asq_pkg::OFF_CTL5: conv_abort = 1'b1;
				asq_pkg::OFF_TEST: conv_abort = s_reg.w_data[asq_pkg::TEST_RST];
				default:           conv_abort = 1'b0;
			endcase
		end
	end

	// Bus, registers and sequencer
	always_comb begin
		s_next = s_reg;
		s_next.kick = 1'b0;
		// Divider reloads on each tick and on a start, so the first bit decision
		// never uses a comparator answer that still belongs to the old trial word
		if (tick || s_reg.kick) begin
			s_next.divcnt = {1'b0, s_reg.ctl4} + 5'(asq_pkg::BASE_DIV - 1);
		end else begin
			s_next.divcnt = s_reg.divcnt - 5'h01;
		end
		// Address and data capture, either order
		if (s_axi_awvalid && !s_reg.aw_got) begin
			s_next.aw_got = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_reg.w_got) begin
			s_next.w_got = 1'b1;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		// Completion of one conversion stores its result
		if (sar_done && s_reg.active) begin
			s_next.slot = s_reg.slot + 3'h1;
			if (s_reg.step == seq_len_m1) begin
				s_next.status[asq_pkg::ST_SCF] = 1'b1;
				s_next.step = 3'h0;
				s_next.kick = s_reg.ctl5[asq_pkg::CTL5_SCAN];
				s_next.active = s_reg.ctl5[asq_pkg::CTL5_SCAN];
				if (!s_reg.ctl3[asq_pkg::CTL3_FIFO]) begin
					s_next.slot = 3'h0;
				end
			end else begin
				s_next.step = s_reg.step + 3'h1;
				s_next.kick = 1'b1;
			end
		end
		// Register write
		if (wr_fire) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = asq_pkg::RESP_OKAY;
			case (s_reg.aw_addr)
				asq_pkg::OFF_CTL2: if (s_reg.w_strb[0]) s_next.ctl2 = s_reg.w_data[1:0];
				asq_pkg::OFF_CTL3: if (s_reg.w_strb[0]) s_next.ctl3 = s_reg.w_data[1:0];
				asq_pkg::OFF_CTL4: if (s_reg.w_strb[0]) s_next.ctl4 = s_reg.w_data[3:0];
				asq_pkg::OFF_CTL5: begin
					if (s_reg.w_strb[0]) s_next.ctl5 = s_reg.w_data[5:0];
					s_next.status = 2'h0;
				end
				asq_pkg::OFF_STATUS: if (s_reg.w_strb[0]) s_next.status = s_reg.status & ~s_reg.w_data[1:0];
				asq_pkg::OFF_IMASK: if (s_reg.w_strb[0]) s_next.mask = s_reg.w_data[1:0];
				asq_pkg::OFF_TEST: ;
				default: s_next.bresp = asq_pkg::RESP_SLVERR;
			endcase
			if (conv_abort) begin
				s_next.step = 3'h0;
				s_next.slot = 3'h0;
				s_next.active = 1'b1;
				s_next.kick = 1'b1;
			end
			if (s_reg.aw_addr == asq_pkg::OFF_TEST && s_reg.w_data[asq_pkg::TEST_RST]) begin
				s_next.active = 1'b0;
				s_next.kick = 1'b0;
			end
		end
		// Sequence end flag survives a same-cycle status-register clear, though not a control five write
		if (sar_done && s_reg.active && s_reg.step == seq_len_m1 &&
		    !(wr_fire && s_reg.aw_addr == asq_pkg::OFF_CTL5)) begin
			s_next.status[asq_pkg::ST_SCF] = 1'b1;
		end
		s_next.status[asq_pkg::ST_CONV] = sar_busy || s_next.kick;
		// Read: address phase, then data one cycle later, result slots from the store
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_reg.rpend && !s_reg.rvalid) begin
			s_next.rpend = 1'b1;
			s_next.ar_addr = s_axi_araddr;
		end
		if (s_reg.rpend) begin
			s_next.rpend = 1'b0;
			s_next.rvalid = 1'b1;
			s_next.rresp = asq_pkg::RESP_OKAY;
			case (s_reg.ar_addr)
				asq_pkg::OFF_CTL2:   s_next.rdata = {30'h0, s_reg.ctl2};
				asq_pkg::OFF_CTL3:   s_next.rdata = {30'h0, s_reg.ctl3};
				asq_pkg::OFF_CTL4:   s_next.rdata = {28'h0, s_reg.ctl4};
				asq_pkg::OFF_CTL5:   s_next.rdata = {26'h0, s_reg.ctl5};
				asq_pkg::OFF_STATUS: s_next.rdata = {30'h0, s_reg.status};
				asq_pkg::OFF_IMASK:  s_next.rdata = {30'h0, s_reg.mask};
				asq_pkg::OFF_TEST:   s_next.rdata = {{(32-BITS){1'b0}}, sar_trial};
				default: begin
					if (s_reg.ar_addr >= 8'h20 && s_reg.ar_addr < 8'h40) begin
						s_next.rdata = {16'h0, ram_rd};
					end else begin
						s_next.rdata = 32'h0;
						s_next.rresp = asq_pkg::RESP_SLVERR;
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.ctl2 <= asq_pkg::CTL2_RST;
			s_reg.ctl3 <= asq_pkg::CTL3_RST;
			s_reg.ctl4 <= asq_pkg::CTL4_RST;
			s_reg.ctl5 <= asq_pkg::CTL5_RST;
			s_reg.mask <= asq_pkg::MASK_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Conversion engine
	asq_sar #(.BITS(BITS)) u_sar (
		.clk      (clk),
		.rst      (rst),
		.start    (s_reg.kick),
		.abort    (conv_abort),
		.tick     (tick),
		.cmp_high (cmp_high),
		.trial    (sar_trial),
		.busy     (sar_busy),
		.done     (sar_done)
	);

	// Result store
	asq_ram #(.WIDTH(16), .DEPTH(8), .AW(3)) u_ram (
		.clk     (clk),
		.wr_en   (sar_done && s_reg.active),
		.wr_addr (s_reg.slot),
		.wr_data (ram_wd),
		.rd_addr (rd_slot),
		.rd_data (ram_rd)
	);

	// Multiplexer select: start channel plus step, references when special is set
	assign mux_chan    = asq_pkg::seq_chan(s_reg.ctl5[2:0], s_reg.step);
	assign mux_special = s_reg.ctl5[asq_pkg::CTL5_SPECIAL];
	assign dac_trial   = sar_trial;

	// Bus outputs
	assign s_axi_awready = !s_reg.aw_got;
	assign s_axi_wready  = !s_reg.w_got;
	assign s_axi_bvalid  = s_reg.bvalid;
	assign s_axi_bresp   = s_reg.bresp;
	assign s_axi_arready = !s_reg.rpend && !s_reg.rvalid;
	assign s_axi_rvalid  = s_reg.rvalid;
	assign s_axi_rdata   = s_reg.rdata;
	assign s_axi_rresp   = s_reg.rresp;
	// Level interrupt: sequence-complete flag gated by its mask bit
	assign irq           = |(s_reg.status & s_reg.mask & 2'h1);
endmodule
`default_nettype wire

// ===== asq_pkg.sv
// Package for the converter sequencing block: register offsets, field positions, reset values.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package asq_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTL2   = 8'h00;
	localparam logic [7:0] OFF_CTL3   = 8'h04;
	localparam logic [7:0] OFF_CTL4   = 8'h08;
	localparam logic [7:0] OFF_CTL5   = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_TEST   = 8'h14;
	localparam logic [7:0] OFF_RESULT = 8'h18;
	localparam logic [7:0] OFF_IMASK  = 8'h1c;
	// Control two fields
	localparam int CTL2_JUSTIFY = 0;
	localparam int CTL2_HALTWAI = 1;
	// Control three fields
	localparam int CTL3_SINGLE  = 0;
	localparam int CTL3_FIFO    = 1;
	// Control four: conversion time select, low bits
	localparam int CTL4_CYC_W   = 4;
	// Control five fields
	localparam int CTL5_CHAN_LO = 0;
	localparam int CTL5_SPECIAL = 3;
	localparam int CTL5_EIGHT   = 4;
	localparam int CTL5_SCAN    = 5;
	// Status fields
	localparam int ST_SCF       = 0;
	localparam int ST_CONV      = 1;
	// Test register fields
	localparam int TEST_RST     = 31;
	// Reset values, chosen to keep the older device's behaviour
	localparam logic [1:0] CTL2_RST = 2'h0;
	localparam logic [1:0] CTL3_RST = 2'h0;
	localparam logic [3:0] CTL4_RST = 4'h0;
	localparam logic [5:0] CTL5_RST = 6'h00;
	localparam logic [1:0] MASK_RST = 2'h0;
	// Converter timing: one bit decision per divided tick
	localparam int SAR_BITS     = 10;
	localparam int BASE_DIV     = 2;
	// Bus response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Pick the channel of step n of a sequence
	function automatic logic [2:0] seq_chan(input logic [2:0] first, input logic [2:0] step);
		seq_chan = first + step;
	endfunction
endpackage

// ===== asq_ram.sv
// Result store for eight converted words.
// Assumes one clock; read data come from a register one cycle after the address.
`timescale 1ns/100ps
`default_nettype none
module asq_ram #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	// Clock
	input  wire logic             clk,
	// Write side
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read side
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Registered write and read
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// ===== asq_sar.sv
// Successive-approximation engine: steps one bit per tick against the analog comparator.
// Assumes the comparator answer is synchronous and valid one tick after the trial word.
`timescale 1ns/100ps
`default_nettype none
module asq_sar #(
	parameter int BITS = 10
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rst,
	// Control
	input  wire logic            start,
	input  wire logic            abort,
	input  wire logic            tick,
	// Analog side
	input  wire logic            cmp_high,
	output logic      [BITS-1:0] trial,
	// Result
	output logic                 busy,
	output logic                 done
);
	typedef struct packed {
		logic [BITS-1:0] word;
		logic [BITS-1:0] bitsel;
		logic            busy;
		logic            done;
	} asq_sar_t;
	asq_sar_t s_reg, s_next;

	// Bit decision per tick
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (abort || start) begin
			s_next.busy = start;
			s_next.word = {1'b1, {(BITS-1){1'b0}}};
			s_next.bitsel = {1'b1, {(BITS-1){1'b0}}};
		end else if (s_reg.busy && tick) begin
			if (!cmp_high) begin
				s_next.word = s_reg.word & ~s_reg.bitsel;
			end
			s_next.bitsel = s_reg.bitsel >> 1;
			s_next.word = s_next.word | (s_reg.bitsel >> 1);
			if (s_reg.bitsel[0]) begin
				s_next.busy = 1'b0;
				s_next.done = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign trial = s_reg.word;
	assign busy  = s_reg.busy;
	assign done  = s_reg.done;
endmodule
`default_nettype wire

// ===== asq_cmp_model.sv
// Comparator model: one fixed analog level per input, answered one clock late.
// Assumes channel, reference select and trial word come from registered outputs.
`timescale 1ns/100ps
`default_nettype none
module asq_cmp_model (
	// Clock
	input  wire logic       clk,
	// Analog side
	input  wire logic [2:0] chan,
	input  wire logic       special,
	input  wire logic [9:0] trial,
	output logic            cmp_high
);
	// Level sits half a step above its code, so the result is the code itself
	always_ff @(posedge clk) begin
		cmp_high <= {special, 3'h0, chan, 3'h5, 1'b1} > {trial, 1'b0};
	end
endmodule
`default_nettype wire

// ===== asq_ctrl_assertions.sv
// Checker for the converter sequencing block, watching its top-level ports only.
// Assumes one clock and a master that offers write address and data together.
`timescale 1ns/100ps
`default_nettype none
module asq_ctrl_chk #(
	parameter int BITS = 10
) (
	// Clock and reset
	input wire logic            clk,
	input wire logic            rst,
	// Register bus
	input wire logic            s_axi_awvalid,
	input wire logic            s_axi_awready,
	input wire logic [7:0]      s_axi_awaddr,
	input wire logic            s_axi_wvalid,
	input wire logic            s_axi_wready,
	input wire logic [31:0]     s_axi_wdata,
	input wire logic [3:0]      s_axi_wstrb,
	input wire logic            s_axi_bvalid,
	input wire logic            s_axi_bready,
	input wire logic [1:0]      s_axi_bresp,
	input wire logic            s_axi_arvalid,
	input wire logic            s_axi_arready,
	input wire logic [7:0]      s_axi_araddr,
	input wire logic            s_axi_rvalid,
	input wire logic            s_axi_rready,
	input wire logic [31:0]     s_axi_rdata,
	input wire logic [1:0]      s_axi_rresp,
	// Analog side and interrupt
	input wire logic [2:0]      mux_chan,
	input wire logic            mux_special,
	input wire logic [BITS-1:0] dac_trial,
	input wire logic            cmp_high,
	input wire logic            irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [2:0] since_aw;
	logic [2:0] first_ch;
	// Cycles since a write address was taken, and the channel a sequence began on
	always_ff @(posedge clk) begin
		if (rst || (s_axi_awvalid && s_axi_awready)) since_aw <= 3'h0;
		else if (since_aw != 3'h7) since_aw <= since_aw + 3'h1;
		if (rst) first_ch <= 3'h0;
		else if (since_aw == 3'h3) first_ch <= mux_chan;
	end
	property p_reset_vals; $past(rst) && !rst |-> !s_axi_bvalid && !s_axi_rvalid && !irq && mux_chan == 3'h0; endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("Outputs not idle after reset");
	property p_chan_step; $changed(mux_chan) && since_aw > 3'h4 |-> mux_chan == $past(mux_chan) + 3'h1 || mux_chan == first_ch; endproperty
	a_chan_step: assert property (p_chan_step) else $error("Channel did not step upward");
	property p_special; $changed(mux_special) |-> since_aw < 3'h3; endproperty
	a_special: assert property (p_special) else $error("Reference select moved without write");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("Write response dropped early");
	property p_wr_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("Write response late");
	property p_rd_lat; s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("Read data late");
	property p_slverr; s_axi_awvalid && s_axi_awready && s_axi_awaddr >= 8'h40 |-> ##[1:3] s_axi_bvalid && s_axi_bresp == asq_pkg::RESP_SLVERR; endproperty
	a_slverr: assert property (p_slverr) else $error("Unmapped write not refused");
	property p_rdata_zero; s_axi_rvalid && s_axi_rresp == asq_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
	a_rdata_zero: assert property (p_rdata_zero) else $error("Refused read carries data");
	property p_aw_busy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("Second write address accepted");
	c_irq: cover property ($rose(irq));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == asq_pkg::RESP_SLVERR);
	c_special: cover property ($rose(mux_special));
endmodule
bind asq_ctrl asq_ctrl_chk #(.BITS(BITS)) i_asq_ctrl_chk (.*);
`default_nettype wire

// ===== tb.sv
// Testbench for the converter sequencing block: register traffic and sequencing checks.
// Assumes asq_ctrl, its checker and the comparator model are compiled beforehand.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clk = 1'b0, rst = 1'b1;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rdat;
	logic        awready, wready, bvalid, arready, rvalid, cmp_high, irq, mux_special;
	logic [1:0]  bresp, rresp, wres, rres;
	logic [2:0]  mux_chan, last_ch = 3'h0;
	logic [9:0]  dac_trial;
	logic [2:0]  chq[$];
	int          bad_count = 0, cmp_count = 0;
	asq_ctrl #(.BITS(10)) i_asq_ctrl (.clk(clk), .rst(rst),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.mux_chan(mux_chan), .mux_special(mux_special), .dac_trial(dac_trial),
		.cmp_high(cmp_high), .irq(irq));
	asq_cmp_model i_asq_cmp_model (.clk(clk), .chan(mux_chan), .special(mux_special),
		.trial(dac_trial), .cmp_high(cmp_high));
	// Clock and a log of each new channel selected
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (mux_chan !== last_ch) begin
			chq.push_back(mux_chan);
			last_ch = mux_chan;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		wres = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rdat = rdata;
		rres = rresp;
		rready <= 1'b0;
	endtask
	task automatic wait_scf();
		int n;
		n = 0;
		do begin
			rd(asq_pkg::OFF_STATUS);
			n++;
		end while (rdat[0] !== 1'b1 && n < 400);
		chk({31'h0, rdat[0]}, 32'h1, "sequence complete in time");
	endtask
	task automatic t_reset();
		rd(asq_pkg::OFF_CTL2);
		chk(rdat, 32'h0, "ctl2 reset");
		rd(asq_pkg::OFF_CTL3);
		chk(rdat, 32'h0, "ctl3 reset");
		rd(asq_pkg::OFF_STATUS);
		chk(rdat, 32'h0, "status reset");
		rd(8'hfc);
		chk({rdat[29:0], rres}, {30'h0, asq_pkg::RESP_SLVERR}, "unmapped read");
		wr(8'hfc, 32'h1);
		chk({30'h0, wres}, {30'h0, asq_pkg::RESP_SLVERR}, "unmapped write");
		$display("t_reset done");
	endtask
	task automatic t_order();
		chq.delete();
		wr(asq_pkg::OFF_CTL5, 32'h05);
		wait_scf();
		for (int i = 0; i < 4; i++) chk({29'h0, chq[i]}, {29'h0, 3'(i + 5)}, "order");
		for (int i = 0; i < 4; i++) begin
			rd(8'(32'h20 + 4 * i));
			chk(rdat, {22'h0, 4'h0, 3'(i + 5), 3'h5}, "result slot");
		end
		rd(asq_pkg::OFF_TEST);
		chk(rdat, 32'h005, "approximation readback");
		$display("t_order done");
	endtask
	task automatic t_special();
		wr(asq_pkg::OFF_CTL2, 32'h1);
		wr(asq_pkg::OFF_CTL3, 32'h3);
		chq.delete();
		wr(asq_pkg::OFF_CTL5, 32'h0a);
		wait_scf();
		chk({31'h0, mux_special}, 32'h1, "reference select");
		chk({29'h0, chq[0]}, 32'h2, "reference picked");
		chk({31'h0, chq[1] === 3'h3}, 32'h0, "single length");
		rd(asq_pkg::OFF_TEST);
		chk(rdat, 32'h215, "reference result");
		rd(8'h20);
		chk(rdat, 32'h8540, "left justified result");
		$display("t_special done");
	endtask
	task automatic t_scan();
		wr(asq_pkg::OFF_IMASK, 32'h1);
		wr(asq_pkg::OFF_CTL5, 32'h21);
		wait_scf();
		chk({31'h0, irq}, 32'h1, "irq raised");
		wr(asq_pkg::OFF_STATUS, 32'h1);
		wait_scf();
		chk({31'h0, rdat[0]}, 32'h1, "flag set again");
		rd(8'h24);
		chk(rdat, 32'h340, "fifo slot advanced");
		wr(asq_pkg::OFF_IMASK, 32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0, "irq masked");
		wr(asq_pkg::OFF_CTL5, 32'h28);
		rd(asq_pkg::OFF_STATUS);
		chk(rdat[1:0], 32'h2, "restart clears flag");
		$display("t_scan done");
	endtask
	task automatic t_abort();
		int n;
		wr(asq_pkg::OFF_CTL3, 32'h0);
		wr(asq_pkg::OFF_CTL4, 32'h0f);
		wr(asq_pkg::OFF_CTL5, 32'h13);
		n = 0;
		while (mux_chan !== 3'h5 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		wr(asq_pkg::OFF_CTL2, 32'h0);
		rd(asq_pkg::OFF_STATUS);
		chk({rdat[1], 1'b0, mux_chan}, 32'h15, "ctl2 write kept sequence");
		wr(asq_pkg::OFF_CTL4, 32'h0f);
		rd(asq_pkg::OFF_STATUS);
		chk({rdat[1], 1'b0, mux_chan}, 32'h13, "ctl4 write restarts");
		wr(asq_pkg::OFF_TEST, 32'h80000000);
		rd(asq_pkg::OFF_STATUS);
		chk({31'h0, rdat[1]}, 32'h0, "converter reset");
		$display("t_abort done");
	endtask
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Main sequence and watchdog
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_order();
		t_special();
		t_scan();
		t_abort();
		final_report();
	end
	initial begin
		repeat (40000) @(posedge clk);
		$display("MISMATCH t=%0t watchdog expired", $time);
		bad_count++;
		final_report();
	end
endmodule
`default_nettype wire
